// ==== sdp_pkg.sv ====
// Constants for the four-bit cascadable datapath slice.
// Assumes a single-clock synchronous design; no bus, all controls are ports.
//
// Operation
// - Sixteen four-bit words, two read ports.
// - First port reads word at first address.
// - Second port reads concurrently; equal addresses match.
// - Writes go only to second-port word.
// - Write data unshifted, shifted up, or down.
// - ALU: add, two subtracts, five logic ops.
// - Operands from ports, direct, aux, zero.
// - Operation plus shift within one cycle.
// - Flags: carry, overflow, zero, sign.
// - Slices cascade via lookahead or ripple carry.
// - Data outputs are three-state capable.
// - Source code selects operand pair (R,S).
// - Function code selects ALU op; carries active-high.
// - Latches follow high clock; writes, aux timing.
// - Destination code selects loads, shifts, output.
package sdp_pkg;
  // ==========================================================================
  // Widths
  localparam int SDP_W     = 4;   // Slice data width
  localparam int SDP_AW    = 4;   // Register file address width
  localparam int SDP_DEPTH = 16;  // Register file words
  localparam int SDP_IW    = 9;   // Microinstruction width
  // ==========================================================================
  // Microinstruction field positions
  localparam int SDP_SRC_LSB = 0; // Operand source group
  localparam int SDP_FN_LSB  = 3; // ALU function group
  localparam int SDP_DST_LSB = 6; // Destination group
  // ==========================================================================
  // Operand source codes
  typedef enum logic [2:0] {
    SDP_SRC_AQ = 3'h0, SDP_SRC_AB = 3'h1, SDP_SRC_ZQ = 3'h2, SDP_SRC_ZB = 3'h3,
    SDP_SRC_ZA = 3'h4, SDP_SRC_DA = 3'h5, SDP_SRC_DQ = 3'h6, SDP_SRC_DZ = 3'h7
  } sdp_src_t;
  // ALU function codes
  typedef enum logic [2:0] {
    SDP_FN_ADD = 3'h0, SDP_FN_SUBR = 3'h1, SDP_FN_SUBS = 3'h2, SDP_FN_OR = 3'h3,
    SDP_FN_AND = 3'h4, SDP_FN_NOTRS = 3'h5, SDP_FN_XOR = 3'h6, SDP_FN_XNOR = 3'h7
  } sdp_fn_t;
  // Destination codes
  typedef enum logic [2:0] {
    SDP_DST_QREG = 3'h0, SDP_DST_NOP = 3'h1, SDP_DST_RAMA = 3'h2, SDP_DST_RAMF = 3'h3,
    SDP_DST_RAMQD = 3'h4, SDP_DST_RAMD = 3'h5, SDP_DST_RAMQU = 3'h6, SDP_DST_RAMU = 3'h7
  } sdp_dst_t;
endpackage

// ==== sdp_slice.sv ====
// Four-bit datapath slice: register file, ALU, shifters, aux register.
// Assumes microinstruction, addresses and data are synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module sdp_slice #(
  parameter int W = sdp_pkg::SDP_W           // Slice width
) (
  input  wire logic         core_clk,         // Slice clock
  input  wire logic         rst_n,            // Reset, only disables the checks
  input  wire logic [8:0]   instr,            // Microinstruction
  input  wire logic [3:0]   addr_a,           // First port address
  input  wire logic [3:0]   addr_b,           // Second port and write address
  input  wire logic [W-1:0] din,              // Direct data input
  input  wire logic         carry_in,         // Carry in, active high
  input  wire logic         out_en_n,         // Output enable, active low
  output logic      [W-1:0] y_o,              // Data output value
  output logic              y_oe_n,           // Data output enable, low drives
  output logic              carry_out,        // Carry out
  output logic              ovr,              // Overflow
  output logic              zero,             // Result all zero
  output logic              sign,             // Result sign bit
  output logic              gen_n,            // Carry generate, active low
  output logic              prop_n,           // Carry propagate, active low
  input  wire logic         ram_lsb_i,        // Shift pin low end, input
  output logic              ram_lsb_o,        // Shift pin low end, output
  output logic              ram_lsb_oe_n,     // Low end drive enable
  input  wire logic         ram_msb_i,        // Shift pin high end, input
  output logic              ram_msb_o,        // Shift pin high end, output
  output logic              ram_msb_oe_n,     // High end drive enable
  input  wire logic         aux_lsb_i,        // Aux shift low end, input
  output logic              aux_lsb_o,        // Aux shift low end, output
  output logic              aux_lsb_oe_n,     // Aux low end drive enable
  input  wire logic         aux_msb_i,        // Aux shift high end, input
  output logic              aux_msb_o,        // Aux shift high end, output
  output logic              aux_msb_oe_n      // Aux high end drive enable
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [W-1:0] aux;                        // Auxiliary register
  } sdp_state_t;

  logic [W-1:0] mem [sdp_pkg::SDP_DEPTH];     // Register file, no reset
  logic [W-1:0] lat_a, lat_b;                 // Port latches
  sdp_state_t   st_ff, nxt_st;                // Registered state
  logic [W-1:0] r_op, s_op, f, ram_wd;        // Operands, result, write data
  logic [W:0]   sum;                          // Sum with carry
  logic         c_msb;                        // Carry into top bit
  logic         ram_we;                       // Register file write
  sdp_pkg::sdp_src_t src;                     // Decoded source
  sdp_pkg::sdp_fn_t  fn;                      // Decoded function
  sdp_pkg::sdp_dst_t dst;                     // Decoded destination
  logic [W-1:0] rr, ss;                       // Adder operands after inversion
  logic [W-1:0] pg, pp;                       // Per-bit generate, propagate

  // Field decode of the nine-bit word
  assign src = sdp_pkg::sdp_src_t'(instr[sdp_pkg::SDP_SRC_LSB +: 3]);
  assign fn  = sdp_pkg::sdp_fn_t'(instr[sdp_pkg::SDP_FN_LSB +: 3]);
  assign dst = sdp_pkg::sdp_dst_t'(instr[sdp_pkg::SDP_DST_LSB +: 3]);

  // ==========================================================================
  // Port latches: open while clock high, hold while low
  // Non-blocking so the aux flop still sees the closed latch values at the edge
  always_latch begin
    if (core_clk) begin
      lat_a <= mem[addr_a];
      lat_b <= mem[addr_b];
    end
  end

  // ==========================================================================
  // Operand selection
  always_comb begin
    case (src)
      sdp_pkg::SDP_SRC_AQ: begin              // First port with aux
        r_op = lat_a;
        s_op = st_ff.aux;
      end
      sdp_pkg::SDP_SRC_AB: begin              // First port with second port
        r_op = lat_a;
        s_op = lat_b;
      end
      sdp_pkg::SDP_SRC_ZQ: begin              // Zero with aux
        r_op = '0;
        s_op = st_ff.aux;
      end
      sdp_pkg::SDP_SRC_ZB: begin              // Zero with second port
        r_op = '0;
        s_op = lat_b;
      end
      sdp_pkg::SDP_SRC_ZA: begin              // Zero with first port
        r_op = '0;
        s_op = lat_a;
      end
      sdp_pkg::SDP_SRC_DA: begin              // Direct data with first port
        r_op = din;
        s_op = lat_a;
      end
      sdp_pkg::SDP_SRC_DQ: begin              // Direct data with aux
        r_op = din;
        s_op = st_ff.aux;
      end
      default: begin                          // Direct data with zero
        r_op = din;
        s_op = '0;
      end
    endcase
  end

  // ==========================================================================
  // ALU; subtraction uses inverted operand plus carry in
  always_comb begin
    rr = (fn == sdp_pkg::SDP_FN_SUBR || fn == sdp_pkg::SDP_FN_NOTRS) ? ~r_op : r_op;
    ss = (fn == sdp_pkg::SDP_FN_SUBS) ? ~s_op : s_op;
    sum = {1'b0, rr} + {1'b0, ss} + {{W{1'b0}}, carry_in};
    c_msb = rr[W-1] ^ ss[W-1] ^ sum[W-1];
    pg = rr & ss;
    pp = rr | ss;
    case (fn)
      sdp_pkg::SDP_FN_ADD, sdp_pkg::SDP_FN_SUBR, sdp_pkg::SDP_FN_SUBS: f = sum[W-1:0];
      sdp_pkg::SDP_FN_OR:    f = r_op | s_op;
      sdp_pkg::SDP_FN_AND:   f = r_op & s_op;
      sdp_pkg::SDP_FN_NOTRS: f = ~r_op & s_op;
      sdp_pkg::SDP_FN_XOR:   f = r_op ^ s_op;
      default:      f = ~(r_op ^ s_op);
    endcase
  end

  // Status flags and cascade terms
  assign carry_out = sum[W];
  assign ovr       = sum[W] ^ c_msb;
  assign zero      = (f == '0);
  assign sign      = f[W-1];
  assign prop_n    = ~(&pp);
  assign gen_n     = ~(pg[3] | (pp[3] & pg[2]) | (pp[3] & pp[2] & pg[1]) | (&pp[3:1] & pg[0]));

  // ==========================================================================
  // Write path shifter and shift pins
  always_comb begin
    ram_we = 1'b1;
    ram_wd = f;
    case (dst)
      sdp_pkg::SDP_DST_QREG, sdp_pkg::SDP_DST_NOP:   ram_we = 1'b0;                 // No write
      sdp_pkg::SDP_DST_RAMQD, sdp_pkg::SDP_DST_RAMD: ram_wd = {ram_msb_i, f[W-1:1]}; // Halve
      sdp_pkg::SDP_DST_RAMQU, sdp_pkg::SDP_DST_RAMU: ram_wd = {f[W-2:0], ram_lsb_i}; // Double
      default:                                       ram_wd = f;
    endcase
  end
  assign ram_lsb_o    = f[0];
  assign ram_lsb_oe_n = ~(dst == sdp_pkg::SDP_DST_RAMQD || dst == sdp_pkg::SDP_DST_RAMD);
  assign ram_msb_o    = f[W-1];
  assign ram_msb_oe_n = ~(dst == sdp_pkg::SDP_DST_RAMQU || dst == sdp_pkg::SDP_DST_RAMU);
  assign aux_lsb_o    = st_ff.aux[0];
  assign aux_lsb_oe_n = ~(dst == sdp_pkg::SDP_DST_RAMQD || dst == sdp_pkg::SDP_DST_RAMD);
  assign aux_msb_o    = st_ff.aux[W-1];
  assign aux_msb_oe_n = ~(dst == sdp_pkg::SDP_DST_RAMQU || dst == sdp_pkg::SDP_DST_RAMU);

  // Register file written while clock low, only at second address
  always_latch begin
    if (!core_clk && ram_we) begin
      mem[addr_b] <= ram_wd;
    end
  end

  // ==========================================================================
  // Aux register next value
  always_comb begin
    nxt_st = st_ff;
    case (dst)
      sdp_pkg::SDP_DST_QREG:  nxt_st.aux = f;                                  // Load result
      sdp_pkg::SDP_DST_RAMQD: nxt_st.aux = {aux_msb_i, st_ff.aux[W-1:1]};      // Shift down
      sdp_pkg::SDP_DST_RAMQU: nxt_st.aux = {st_ff.aux[W-2:0], aux_lsb_i};      // Shift up
      default:       nxt_st.aux = st_ff.aux;
    endcase
  end

  // Aux loads on rising edge, no reset
  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end

  // ==========================================================================
  // Output mux and three-state enable
  assign y_o    = (dst == sdp_pkg::SDP_DST_RAMA) ? lat_a : f;
  assign y_oe_n = out_en_n;

  // ==========================================================================
  // Checks
  // Sampled at the rising edge, while latches still hold the finished cycle
  AST_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    dst != sdp_pkg::SDP_DST_RAMA |-> zero == (y_o == '0)) else $error("zero flag wrong");
  AST_SIGN: assert property (@(posedge core_clk) disable iff (!rst_n)
    sign == y_o[W-1] || dst == sdp_pkg::SDP_DST_RAMA) else $error("sign flag wrong");
  AST_AUXLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    dst == sdp_pkg::SDP_DST_QREG |=> st_ff.aux == $past(f)) else $error("aux not loaded");
  AST_AUXHOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    dst == sdp_pkg::SDP_DST_NOP |=> $stable(st_ff.aux)) else $error("aux changed on no load");
  AST_YSEL: assert property (@(posedge core_clk) disable iff (!rst_n)
    dst == sdp_pkg::SDP_DST_RAMA |-> y_o == lat_a) else $error("output not first port");
  AST_SAMEADDR: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 addr_a == addr_b && $stable(addr_a) && $stable(addr_b) |-> lat_a == lat_b)
    else $error("ports differ on equal address");
  AST_ADD: assert property (@(posedge core_clk) disable iff (!rst_n)
    fn == sdp_pkg::SDP_FN_ADD |-> {carry_out, f} == r_op + s_op + carry_in) else $error("add wrong");
  AST_SHDN: assert property (@(posedge core_clk) disable iff (!rst_n)
    dst == sdp_pkg::SDP_DST_RAMD |-> ram_wd == {ram_msb_i, f[W-1:1]} && !ram_lsb_oe_n)
    else $error("down shift wrong");
  // Subtractions: a low carry in takes one more off the difference
  AST_SUBR: assert property (@(posedge core_clk) disable iff (!rst_n)
    fn == sdp_pkg::SDP_FN_SUBR |-> f == s_op - r_op - {{(W-1){1'b0}}, ~carry_in})
    else $error("s minus r wrong");
  AST_SUBS: assert property (@(posedge core_clk) disable iff (!rst_n)
    fn == sdp_pkg::SDP_FN_SUBS |-> f == r_op - s_op - {{(W-1){1'b0}}, ~carry_in})
    else $error("r minus s wrong");
  // Signed overflow: like-signed operands give a result of the other sign
  AST_OVR: assert property (@(posedge core_clk) disable iff (!rst_n)
    fn == sdp_pkg::SDP_FN_ADD |-> ovr == (r_op[W-1] == s_op[W-1] && f[W-1] != r_op[W-1]))
    else $error("overflow flag wrong");
  AST_SHUP: assert property (@(posedge core_clk) disable iff (!rst_n)
    dst == sdp_pkg::SDP_DST_RAMU |-> ram_wd == {f[W-2:0], ram_lsb_i} && !ram_msb_oe_n)
    else $error("up shift wrong");
  // No shift pin may drive on the non-shifting codes
  AST_NOSHIFT: assert property (@(posedge core_clk) disable iff (!rst_n)
    !instr[sdp_pkg::SDP_DST_LSB + 2] |-> ram_lsb_oe_n && ram_msb_oe_n && aux_lsb_oe_n && aux_msb_oe_n)
    else $error("shift pin driven without shift");
  AST_AUXDN: assert property (@(posedge core_clk) disable iff (!rst_n)
    dst == sdp_pkg::SDP_DST_RAMQD |=> st_ff.aux == {$past(aux_msb_i), $past(st_ff.aux[W-1:1])})
    else $error("aux down shift wrong");
  AST_AUXUP: assert property (@(posedge core_clk) disable iff (!rst_n)
    dst == sdp_pkg::SDP_DST_RAMQU |=> st_ff.aux == {$past(st_ff.aux[W-2:0]), $past(aux_lsb_i)})
    else $error("aux up shift wrong");
endmodule
`default_nettype wire

// ==== sdp_nbr.sv ====
// Neighbouring slice model: resolves one pair of shift end pins.
// Assumes the slice drives an end pin only while its enable is low.
`timescale 1ns/1ns
`default_nettype none
module sdp_nbr (
  input  wire logic lo_oe_n, // Slice low end enable
  input  wire logic lo_o,    // Slice low end value
  input  wire logic hi_oe_n, // Slice high end enable
  input  wire logic hi_o,    // Slice high end value
  input  wire logic fill,    // Neighbour shift-in bit
  output logic      lo_i,    // Resolved low end level
  output logic      hi_i     // Resolved high end level
);
  // ========
  // Neighbour drives whichever end the slice leaves free
  assign lo_i = lo_oe_n ? fill : lo_o;
  assign hi_i = hi_oe_n ? fill : hi_o;
endmodule
`default_nettype wire

// ==== sdp_slice_bench.sv ====
// Self-checking bench for the datapath slice with a reference model.
// Assumes sdp_pkg, sdp_slice and sdp_nbr are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sdp_slice_bench;
  // ========
  // Stimulus, outputs and expected state
  logic       core_clk = 1'b0, rst_n = 1'b0, carry_in = 1'b0, out_en_n = 1'b0, fill = 1'b0;
  logic [8:0] instr = 9'h007; // Idle word: direct zero into aux, keeps checks on known data
  logic [3:0] addr_a = 4'h0, addr_b = 4'h0, din = 4'h0, y_o;
  logic       carry_out, ovr, zero, sign, y_oe_n, rl_i, rl_o, rl_e, rm_i, rm_o, rm_e;
  logic       ql_i, ql_o, ql_e, qm_i, qm_o, qm_e, gn, pn;
  logic [3:0] mem [16]; // Expected register file
  logic [3:0] q;        // Expected aux register
  int         n_errors = 0, num_checks = 0;
  always #50 core_clk = ~core_clk; // 10 MHz clock
  sdp_slice dut (.core_clk(core_clk), .rst_n(rst_n), .instr(instr), .addr_a(addr_a), .addr_b(addr_b),
    .din(din), .carry_in(carry_in), .out_en_n(out_en_n), .y_o(y_o), .y_oe_n(y_oe_n),
    .carry_out(carry_out), .ovr(ovr), .zero(zero), .sign(sign), .gen_n(gn), .prop_n(pn),
    .ram_lsb_i(rl_i), .ram_lsb_o(rl_o), .ram_lsb_oe_n(rl_e), .ram_msb_i(rm_i), .ram_msb_o(rm_o),
    .ram_msb_oe_n(rm_e), .aux_lsb_i(ql_i), .aux_lsb_o(ql_o), .aux_lsb_oe_n(ql_e), .aux_msb_i(qm_i),
    .aux_msb_o(qm_o), .aux_msb_oe_n(qm_e));
  sdp_nbr ram_nbr (.lo_oe_n(rl_e), .lo_o(rl_o), .hi_oe_n(rm_e), .hi_o(rm_o), .fill(fill), .lo_i(rl_i), .hi_i(rm_i));
  sdp_nbr aux_nbr (.lo_oe_n(ql_e), .lo_o(ql_o), .hi_oe_n(qm_e), .hi_o(qm_o), .fill(fill), .lo_i(ql_i), .hi_i(qm_i));
  // ========
  // Compare and verdict
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ========
  // One microinstruction: drive, predict, check, update model
  task automatic op(input logic [2:0] s, f, d, input logic [3:0] a, b, dd, input logic ci);
    logic [3:0] av, bv, r, sv, x, y, fv, c3;
    logic [4:0] sm, g5;
    @(posedge core_clk);
    #1;
    instr = {d, f, s};
    addr_a = a;
    addr_b = b;
    din = dd;
    carry_in = ci;
    fill = ~fill;
    av = mem[a];
    bv = mem[b];
    case (s) // Operand pair
      3'h0: {r, sv} = {av, q};
      3'h1: {r, sv} = {av, bv};
      3'h2: {r, sv} = {4'h0, q};
      3'h3: {r, sv} = {4'h0, bv};
      3'h4: {r, sv} = {4'h0, av};
      3'h5: {r, sv} = {dd, av};
      3'h6: {r, sv} = {dd, q};
      default: {r, sv} = {dd, 4'h0};
    endcase
    x = (f == 3'h1) ? ~r : r;
    y = (f == 3'h2) ? ~sv : sv;
    sm = {1'b0, x} + {1'b0, y} + {4'h0, ci};
    c3 = {1'b0, x[2:0]} + {1'b0, y[2:0]} + {3'h0, ci};
    g5 = {1'b0, x} + {1'b0, y}; // Carry out with no carry in
    case (f) // Function result
      3'h3: fv = r | sv;
      3'h4: fv = r & sv;
      3'h5: fv = ~r & sv;
      3'h6: fv = r ^ sv;
      3'h7: fv = ~(r ^ sv);
      default: fv = sm[3:0];
    endcase
    #40;
    chk("y_o", (d == 3'h2) ? av : fv, y_o);
    chk("flags", {fv == 4'h0, fv[3], out_en_n, 1'b0}, {zero, sign, y_oe_n, 1'b0});
    if (f < 3'h3) chk("carry", {~g5[4], ~&(x | y), sm[4], sm[4] ^ c3[3]},
                      {gn, pn, carry_out, ovr});
    chk("pin_en", d[2] ? (d[1] ? 4'hA : 4'h5) : 4'hF, {rl_e, rm_e, ql_e, qm_e});
    if (d[2]) chk("pins", d[1] ? {2'b00, fv[3], q[3]} : {2'b00, fv[0], q[0]},
                  d[1] ? {2'b00, rm_o, qm_o} : {2'b00, rl_o, ql_o});
    if (d == 3'h0) q = fv;
    if (d == 3'h4) q = {fill, q[3:1]};
    if (d == 3'h6) q = {q[2:0], fill};
    if (d >= 3'h2) mem[b] = d[2] ? (d[1] ? {fv[2:0], fill} : {fill, fv[3:1]}) : fv;
  endtask
  // ========
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) op(3'h7, 3'h0, 3'h3, i[3:0] + 4'h1, i[3:0], ~i[3:0], 1'b0);
    op(3'h7, 3'h0, 3'h0, 4'h0, 4'h0, 4'h9, 1'b0);
    for (int k = 0; k < 128; k++) op(k[2:0], k[5:3], 3'h1, k[3:0], k[6:3], 4'h7 ^ k[4:1], k[6]);
    for (int k = 0; k < 16; k++) op(3'h1, k[3] ? 3'h6 : 3'h0, k[2:0], k[3:0], 4'h5, 4'h0, k[0]);
    for (int i = 0; i < 16; i++) op(3'h4, 3'h0, 3'h1, i[3:0], 4'h0, 4'h0, 1'b0);
    @(posedge core_clk);
    #1;
    out_en_n = 1'b1;
    op(3'h3, 3'h3, 3'h1, 4'h2, 4'h5, 4'h0, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
